// ---- rtl/ccd_core.sv ----
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Complement file, route by destination, zero
// - Clear file writes 00h, sets zero
// - Clear accumulator, set zero flag
// - Decrement file, route by destination, zero
// - Decrement-skip routes result, flags untouched
// - Zero result replaces next instruction with no-op
// - Branch: literal to low, latch 6:3 high
// - Branch takes two cycles, no flags
module ccd_core #(
	parameter int FILE_DEPTH = ccd_pkg::FILE_DEPTH_DEF   // File registers held
) (
	input  wire logic                           aclk,     // Clock, 200 MHz
	input  wire logic                           aresetn,  // Sync reset, low
	input  wire logic [ccd_pkg::AXI_ADDR_W-1:0] awaddr,   // Write address
	input  wire logic [2:0]                     awprot,   // Unused protection
	input  wire logic                           awvalid,  // Write address valid
	output logic                                awready,  // Write address ready
	input  wire logic [31:0]                    wdata,    // Write data
	input  wire logic [3:0]                     wstrb,    // Byte strobes
	input  wire logic                           wvalid,   // Write data valid
	output logic                                wready,   // Write data ready
	output logic      [1:0]                     bresp,    // Write response
	output logic                                bvalid,   // Write response valid
	input  wire logic                           bready,   // Write response ready
	input  wire logic [ccd_pkg::AXI_ADDR_W-1:0] araddr,   // Read address
	input  wire logic [2:0]                     arprot,   // Unused protection
	input  wire logic                           arvalid,  // Read address valid
	output logic                                arready,  // Read address ready
	output logic      [31:0]                    rdata,    // Read data
	output logic      [1:0]                     rresp,    // Read response
	output logic                                rvalid,   // Read data valid
	input  wire logic                           rready    // Read data ready
);
	import ccd_pkg::*;
	// Storage is addressed by a 7-bit field, so the depth is fixed
	if (FILE_DEPTH != FILE_DEPTH_DEF) begin : g_chk
		$error("FILE_DEPTH must equal the 7-bit file address space");
	end
	// Bus side state
	logic                  aw_full_reg, aw_full_next;    // Address held
	logic                  w_full_reg, w_full_next;      // Data held
	logic [AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;    // Held address
	logic [31:0]           w_data_reg, w_data_next;      // Held data
	logic [3:0]            w_strb_reg, w_strb_next;      // Held strobes
	logic                  awready_reg, awready_next, wready_reg, wready_next; // Readies
	logic                  bvalid_reg, bvalid_next, arready_reg, arready_next; // Handshakes
	logic                  rvalid_reg, rvalid_next;      // Read data valid
	logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next; // Responses
	logic [31:0]           rdata_reg, rdata_next;        // Read data
	// Core state
	ccd_state_t            state_reg, state_next;        // Sequencer
	logic [INSTR_W-1:0]    instr_reg, instr_next;        // Issued instruction
	logic [DATA_W-1:0]     acc_reg, acc_next;            // Accumulator
	logic                  zero_reg, zero_next;          // Zero flag
	logic [LATCH_W-1:0]    latch_reg, latch_next;        // Upper jump latch
	logic [PC_W-1:0]       pc_reg, pc_next;              // Program counter
	logic [FADDR_W-1:0]    faddr_reg, faddr_next;        // File window address
	logic                  skip_reg, skip_next;          // Drop next instruction
	logic                  illegal_reg, illegal_next;    // Sticky bad opcode
	logic [DATA_W-1:0]     file_mem [FILE_DEPTH];        // File registers
	logic [DATA_W-1:0]     file_next [FILE_DEPTH];
	// Execute stage outputs
	logic [FADDR_W-1:0]    f_idx;                        // Operand address
	logic [DATA_W-1:0]     f_val;                        // Operand value
	logic [DATA_W-1:0]     ex_acc, ex_fdata;
	logic                  ex_fwe, ex_zero, ex_two, ex_skip, ex_ill;
	logic [PC_W-1:0]       ex_pc;
	// Write decode
	logic                  do_write;                     // Write executes now
	logic                  wr_err;                       // Write refused
	logic [31:0]           wr_merged;                    // Old word with new lanes
	logic                  ex_go;                        // Real execute cycle
	assign f_idx = instr_reg[FADR_MSB:0];
	assign f_val = file_mem[f_idx];
	assign ex_go = (state_reg == ST_EXEC) && !skip_reg;
	// Register view of the block
	function automatic logic [31:0] read_word(input logic [AXI_ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == REG_INSTR) begin
			v[INSTR_W-1:0] = instr_reg;
		end else if (a == REG_ACC) begin
			v[DATA_W-1:0] = acc_reg;
		end else if (a == REG_STATUS) begin
			v[ST_ZERO]    = zero_reg;
			v[ST_BUSY]    = (state_reg != ST_IDLE);
			v[ST_SKIP]    = skip_reg;
			v[ST_ILLEGAL] = illegal_reg;
		end else if (a == REG_LATCH) begin
			v[LATCH_W-1:0] = latch_reg;
		end else if (a == REG_PC) begin
			v[PC_W-1:0] = pc_reg;
		end else if (a == REG_FADDR) begin
			v[FADDR_W-1:0] = faddr_reg;
		end else if (a == REG_FDATA) begin
			v[DATA_W-1:0] = file_mem[faddr_reg];
		end
		return v;
	endfunction : read_word
	// Mapped offsets, all readable
	function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
		return (a == REG_INSTR) || (a == REG_ACC) || (a == REG_STATUS) ||
			(a == REG_LATCH) || (a == REG_PC) || (a == REG_FADDR) || (a == REG_FDATA);
	endfunction : mapped
	ccd_exec u_exec (
		.instr     (instr_reg),
		.acc       (acc_reg),
		.fval      (f_val),
		.zero      (zero_reg),
		.latch     (latch_reg),
		.pc        (pc_reg),
		.acc_new   (ex_acc),
		.file_we   (ex_fwe),
		.file_new  (ex_fdata),
		.zero_new  (ex_zero),
		.pc_new    (ex_pc),
		.two_cycle (ex_two),
		.skip_set  (ex_skip),
		.illegal   (ex_ill)
	);
	// Writes are refused while busy so software never races execution
	assign do_write  = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_err    = !mapped(aw_addr_reg) || (aw_addr_reg == REG_PC) ||
		(state_reg != ST_IDLE);
	// A process, so state read inside the function also refreshes the merge
	always_comb wr_merged = ccd_merge(read_word(aw_addr_reg), w_data_reg, w_strb_reg);
	// Bus slave next state
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		// Address and data taken in either order
		if (awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready_reg) begin
			w_full_next = 1'b1;
			w_data_next = wdata;
			w_strb_next = wstrb;
		end
		// Response once both halves are in
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		// Single read in flight
		if (arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rdata_next  = read_word(araddr);
			rresp_next  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		awready_next = !aw_full_next;
		wready_next  = !w_full_next;
		arready_next = !rvalid_next;
	end
	// Bus slave registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end
	// Core next state: software writes when idle, execution otherwise
	always_comb begin
		state_next   = state_reg;
		instr_next   = instr_reg;
		acc_next     = acc_reg;
		zero_next    = zero_reg;
		latch_next   = latch_reg;
		pc_next      = pc_reg;
		faddr_next   = faddr_reg;
		skip_next    = skip_reg;
		illegal_next = illegal_reg;
		file_next    = file_mem;
		case (state_reg)
			ST_IDLE: begin
				if (do_write && !wr_err) begin
					if (aw_addr_reg == REG_INSTR) begin
						instr_next = wr_merged[INSTR_W-1:0];
						state_next = ST_EXEC;
					end else if (aw_addr_reg == REG_ACC) begin
						acc_next = wr_merged[DATA_W-1:0];
					end else if (aw_addr_reg == REG_STATUS) begin
						zero_next = wr_merged[ST_ZERO];
						// Write one to clear the sticky bit
						if (w_strb_reg[0] && w_data_reg[ST_ILLEGAL]) begin
							illegal_next = 1'b0;
						end
					end else if (aw_addr_reg == REG_LATCH) begin
						latch_next = wr_merged[LATCH_W-1:0];
					end else if (aw_addr_reg == REG_FADDR) begin
						faddr_next = wr_merged[FADDR_W-1:0];
					end else if (aw_addr_reg == REG_FDATA) begin
						file_next[faddr_reg] = wr_merged[DATA_W-1:0];
					end
				end
			end
			ST_EXEC: begin
				if (skip_reg) begin
					skip_next  = 1'b0;
					pc_next    = PC_W'(pc_reg + 15'h0001);
					state_next = ST_IDLE;
				end else begin
					acc_next  = ex_acc;
					zero_next = ex_zero;
					pc_next   = ex_pc;
					skip_next = ex_skip;
					if (ex_fwe) begin
						file_next[f_idx] = ex_fdata;
					end
					if (ex_ill) begin
						illegal_next = 1'b1;
					end
					state_next = ex_two ? ST_WAIT : ST_IDLE;
				end
			end
			// Branch second cycle and stray codes fall back to idle
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end
	// Core registers; file contents are not reset, like real RAM
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= ST_IDLE;
			instr_reg   <= '0;
			acc_reg     <= ACC_RST;
			zero_reg    <= 1'b0;
			latch_reg   <= LATCH_RST;
			pc_reg      <= PC_RST;
			faddr_reg   <= '0;
			skip_reg    <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			instr_reg   <= instr_next;
			acc_reg     <= acc_next;
			zero_reg    <= zero_next;
			latch_reg   <= latch_next;
			pc_reg      <= pc_next;
			faddr_reg   <= faddr_next;
			skip_reg    <= skip_next;
			illegal_reg <= illegal_next;
		end
		file_mem <= file_next;
	end
	assign awready = awready_reg;
	assign wready  = wready_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = arready_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire is_file = instr_reg[CLS_MSB:CLS_LSB] == CLS_FILE;  // File-class instruction
	AST_COMPLEMENT: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_COMPLEMENT && !instr_reg[DEST_BIT]
		|=> acc_reg == ~$past(f_val) && zero_reg == &$past(f_val)) else $error("complement wrong");
	AST_CLEAR_FILE: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_CLEAR_FILE
		|=> file_mem[$past(f_idx)] == 8'h00 && zero_reg) else $error("clear file failed");
	AST_CLEAR_ACC: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_CLEAR_ACC
		|=> acc_reg == 8'h00 && zero_reg && !$stable(pc_reg)) else $error("clear accumulator failed");
	AST_DECREMENT: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_DECREMENT && instr_reg[DEST_BIT]
		|=> file_mem[$past(f_idx)] == 8'($past(f_val) - 8'h01) && $stable(acc_reg))
		else $error("decrement to file wrong");
	AST_DEC_SKIP_FLAGS: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_DEC_SKIP
		|=> zero_reg == $past(zero_reg)) else $error("decrement-skip touched zero flag");
	AST_SKIP_ARM: assert property (
		ex_go && is_file && instr_reg[SUB_MSB:SUB_LSB] == SUB_DEC_SKIP
		|=> skip_reg == ($past(f_val) == 8'h01)) else $error("skip not armed on zero result");
	AST_SKIP_NOP: assert property (
		state_reg == ST_EXEC && skip_reg
		|=> !skip_reg && $stable(acc_reg) && $stable(zero_reg) && state_reg == ST_IDLE)
		else $error("dropped instruction had an effect");
	AST_BRANCH_PC: assert property (
		ex_go && instr_reg[CLS_MSB:CLS_LSB] == CLS_BRANCH
		|=> pc_reg == {$past(latch_reg[LATCH_HI:LATCH_LO]), $past(instr_reg[LIT_W-1:0])})
		else $error("branch target wrong");
	AST_BRANCH_TIME: assert property (
		ex_go && instr_reg[CLS_MSB:CLS_LSB] == CLS_BRANCH
		|=> state_reg == ST_WAIT && $stable(zero_reg) ##1 state_reg == ST_IDLE)
		else $error("branch not two cycles");

endmodule : ccd_core

// ---- rtl/ccd_pkg.sv ----
package ccd_pkg;

	// Widths of the core datapath
	localparam int DATA_W   = 8;            // File register and accumulator width
	localparam int PC_W     = 15;           // Program counter width
	localparam int INSTR_W  = 14;           // Instruction word width
	localparam int LIT_W    = 11;           // Branch literal width
	localparam int FADDR_W  = 7;            // File address width
	localparam int LATCH_W  = 7;            // Upper jump latch width
	localparam int FILE_DEPTH_DEF = 128;    // File registers held here
	localparam int AXI_ADDR_W = 8;          // Register bus address width

	// Register byte offsets
	localparam logic [7:0] REG_INSTR  = 8'h00;  // Issue an instruction
	localparam logic [7:0] REG_ACC    = 8'h04;  // Accumulator
	localparam logic [7:0] REG_STATUS = 8'h08;  // Zero, busy, skip, illegal
	localparam logic [7:0] REG_LATCH  = 8'h0C;  // Upper jump latch
	localparam logic [7:0] REG_PC     = 8'h10;  // Program counter, read only
	localparam logic [7:0] REG_FADDR  = 8'h14;  // File window address
	localparam logic [7:0] REG_FDATA  = 8'h18;  // File window data

	// Instruction fields
	localparam int CLS_MSB  = 13;           // Class field top
	localparam int CLS_LSB  = 11;           // Class field bottom
	localparam int SUB_MSB  = 10;           // Sub-op field top
	localparam int SUB_LSB  = 8;            // Sub-op field bottom
	localparam int DEST_BIT = 7;            // Destination select
	localparam int FADR_MSB = 6;            // File address top
	localparam int LATCH_HI = 6;            // Latch bits feeding PC top
	localparam int LATCH_LO = 3;            // Latch bits feeding PC top

	// Status register bits
	localparam int ST_ZERO    = 0;          // Zero flag
	localparam int ST_BUSY    = 1;          // Instruction in flight
	localparam int ST_SKIP    = 2;          // Next instruction will be dropped
	localparam int ST_ILLEGAL = 3;          // Sticky unknown opcode

	// Class and sub-op codes
	localparam logic [2:0] CLS_FILE       = 3'h0;
	localparam logic [2:0] CLS_BRANCH     = 3'h5;
	localparam logic [2:0] SUB_NOP        = 3'h0;
	localparam logic [2:0] SUB_COMPLEMENT = 3'h1;
	localparam logic [2:0] SUB_CLEAR_FILE = 3'h2;
	localparam logic [2:0] SUB_CLEAR_ACC  = 3'h3;
	localparam logic [2:0] SUB_DECREMENT  = 3'h4;
	localparam logic [2:0] SUB_DEC_SKIP   = 3'h5;

	// Reset values
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [14:0] PC_RST    = 15'h0000;
	localparam logic [6:0]  LATCH_RST = 7'h00;
	localparam logic [7:0]  FILE_RST  = 8'h00;
	localparam logic [7:0]  ONE_BYTE  = 8'h01;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} ccd_state_t;

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] ccd_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : ccd_merge

endpackage : ccd_pkg

// ---- rtl/ccd_exec.sv ----
`timescale 1ns/1ps
// Combinational execute stage for one instruction
module ccd_exec (
	input  wire logic [ccd_pkg::INSTR_W-1:0] instr,      // Instruction word
	input  wire logic [ccd_pkg::DATA_W-1:0]  acc,        // Accumulator now
	input  wire logic [ccd_pkg::DATA_W-1:0]  fval,       // Addressed file value
	input  wire logic                        zero,       // Zero flag now
	input  wire logic [ccd_pkg::LATCH_W-1:0] latch,      // Upper jump latch
	input  wire logic [ccd_pkg::PC_W-1:0]    pc,         // Program counter now
	output logic      [ccd_pkg::DATA_W-1:0]  acc_new,    // Next accumulator
	output logic                             file_we,    // File write enable
	output logic      [ccd_pkg::DATA_W-1:0]  file_new,   // File write data
	output logic                             zero_new,   // Next zero flag
	output logic      [ccd_pkg::PC_W-1:0]    pc_new,     // Next program counter
	output logic                             two_cycle,  // Needs a second cycle
	output logic                             skip_set,   // Drop next instruction
	output logic                             illegal     // Unknown encoding
);
	import ccd_pkg::*;

	logic [2:0]        cls;                  // Class field
	logic [2:0]        sub;                  // Sub-op field
	logic              dest;                 // 1 = file, 0 = accumulator
	logic [DATA_W-1:0] res;                  // ALU result

	assign cls  = instr[CLS_MSB:CLS_LSB];
	assign sub  = instr[SUB_MSB:SUB_LSB];
	assign dest = instr[DEST_BIT];

	// Decode and compute
	always_comb begin
		acc_new   = acc;
		file_we   = 1'b0;
		file_new  = fval;
		zero_new  = zero;
		pc_new    = PC_W'(pc + 15'h0001);
		two_cycle = 1'b0;
		skip_set  = 1'b0;
		illegal   = 1'b0;
		res       = fval;
		if (cls == CLS_BRANCH) begin
			pc_new    = {latch[LATCH_HI:LATCH_LO], instr[LIT_W-1:0]};
			two_cycle = 1'b1;
		end else if (cls == CLS_FILE) begin
			case (sub)
				SUB_NOP: begin
					res = fval;
				end
				SUB_COMPLEMENT, SUB_DECREMENT, SUB_DEC_SKIP: begin
					res = (sub == SUB_COMPLEMENT) ? ~fval : DATA_W'(fval - ONE_BYTE);
					if (dest) begin
						file_we  = 1'b1;
						file_new = res;
					end else begin
						acc_new = res;
					end
					// no flag change on skip form
					if (sub != SUB_DEC_SKIP) begin
						zero_new = (res == FILE_RST);
					end
					skip_set = (sub == SUB_DEC_SKIP) && (res == FILE_RST);
				end
				SUB_CLEAR_FILE: begin
					file_we  = 1'b1;
					file_new = FILE_RST;
					zero_new = 1'b1;
				end
				SUB_CLEAR_ACC: begin
					acc_new  = ACC_RST;
					zero_new = 1'b1;
				end
				default: begin
					illegal = 1'b1;
				end
			endcase
		end else begin
			illegal = 1'b1;
		end
	end

endmodule : ccd_exec

// ---- verification/ccd_core_tb_top.sv ----
`timescale 1ns/1ps
// Bench: AXI4-Lite master, integer model of the core, compare at every result
module ccd_core_tb_top;
	import ccd_pkg::*;

	logic        aclk    = 1'b0;    // 200 MHz clock
	logic        aresetn = 1'b0;    // Sync reset, low
	logic [7:0]  awaddr  = 8'h00;   // Write address
	logic        awvalid = 1'b0;    // Write address valid
	logic [31:0] wdata   = 32'h0;   // Write data
	logic        wvalid  = 1'b0;    // Write data valid
	logic        bready  = 1'b0;    // Write response ready
	logic [7:0]  araddr  = 8'h00;   // Read address
	logic        arvalid = 1'b0;    // Read address valid
	logic        rready  = 1'b0;    // Read data ready
	logic        awready, wready, bvalid, arready, rvalid; // Slave handshakes
	logic [1:0]  bresp, rresp;      // Responses
	logic [31:0] rdata;             // Read data
	int          fail_count = 0;    // Mismatches
	int          n_checks   = 0;    // Comparisons
	int          seed       = 15;   // Random seed
	int          m_file[128];       // Model file registers
	int          m_acc, m_zero, m_pc, m_latch, m_skip, m_ill, m_fa; // Model state
	logic [31:0] rv;                // Scratch read value
	logic [1:0]  rs;                // Scratch response

	// Free-running clock
	always #2.5 aclk = ~aclk;

	// Strobes and protection tied: full-word access only
	ccd_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// One write; each channel released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	// One read; data taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 1'b0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd

	// Write expecting OKAY
	task automatic wrk(input logic [7:0] a, input int d);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, RESP_OKAY);
	endtask : wrk

	// Set up operand, zero flag and latch in design and model
	task automatic prep(input int fa, input int fv, input int z, input int lat);
		m_fa = fa & 127;
		m_file[m_fa] = fv & 255;
		m_zero = z & 1;
		m_latch = lat & 127;
		wrk(REG_FADDR, m_fa);
		wrk(REG_FDATA, m_file[m_fa]);
		wrk(REG_STATUS, m_zero);
		wrk(REG_LATCH, m_latch);
	endtask : prep

	// Issue one instruction, advance the model, compare accumulator, window file data, status and PC
	task automatic run(input logic [13:0] ins);
		int fv;
		int res;
		fv = m_file[ins[6:0]];
		wrk(REG_INSTR, ins);
		repeat (2) @(posedge aclk);
		if (m_skip) begin
			m_skip = 0;
			m_pc = (m_pc + 1) & 32'h7FFF;
		end else if (ins[13:11] == CLS_BRANCH) begin
			m_pc = (((m_latch >> 3) & 15) << 11) | ins[10:0];
		end else if (ins[13:11] != CLS_FILE || ins[10:8] > SUB_DEC_SKIP) begin
			m_ill = 1;
			m_pc = (m_pc + 1) & 32'h7FFF;
		end else begin
			m_pc = (m_pc + 1) & 32'h7FFF;
			res = (ins[10:8] == SUB_COMPLEMENT) ? (~fv & 255) : ((fv - 1) & 255);
			case (ins[10:8])
				SUB_CLEAR_FILE: begin
					m_file[ins[6:0]] = 0;
					m_zero = 1;
				end
				SUB_CLEAR_ACC: begin
					m_acc = 0;
					m_zero = 1;
				end
				SUB_NOP: begin
				end
				default: begin
					if (ins[10:8] == SUB_DEC_SKIP) m_skip = (res == 0);
					else m_zero = (res == 0);
					if (ins[7]) m_file[ins[6:0]] = res;
					else m_acc = res;
				end
			endcase
		end
		rd(REG_ACC, rv, rs);
		chk(rv, m_acc);
		rd(REG_FDATA, rv, rs);
		chk(rv, m_file[m_fa]);
		rd(REG_STATUS, rv, rs);
		chk(rv, m_ill * 8 + m_skip * 4 + m_zero);
		rd(REG_PC, rv, rs);
		chk(rv, m_pc);
	endtask : run

	// Counts and verdict, the single end of the run
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// Watchdog: far beyond the fewer than two thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		close_out();
	end

	// Main sequence
	initial begin
		int sel;
		m_acc = 0; m_zero = 0; m_pc = 0; m_latch = 0; m_skip = 0; m_ill = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(REG_STATUS, rv, rs);
		chk(rv, 32'h0);
		rd(REG_PC, rv, rs);
		chk(rv, 32'h0);
		// Unmapped read and read-only PC both refused
		rd(8'h1C, rv, rs);
		chk({rv[31:2], rs}, {30'h0, RESP_SLVERR});
		wr(REG_PC, 32'h0000_1234, rs);
		chk(rs, RESP_SLVERR);
		// Refused write leaves the counter alone
		rd(REG_PC, rv, rs);
		chk(rv, 32'h0);
		$display("test reset and map done");
		// Zero result drops the following branch, then a full-range branch and wrap
		prep(5, 1, 0, 7'h78);
		run({CLS_FILE, SUB_DEC_SKIP, 1'b1, 7'h05});
		run({CLS_BRANCH, 11'h123});
		run({CLS_BRANCH, 11'h7FF});
		run({CLS_FILE, SUB_NOP, 8'h00});
		$display("test skip and branch done");
		// Random mix of every operation, destination and boundary operand
		for (int i = 0; i < 48; i++) begin
			sel = $random(seed) & 3;
			prep($random(seed), (sel == 0) ? 1 : (sel == 1) ? 0 : $random(seed),
				$random(seed), $random(seed));
			sel = $random(seed) & 7;
			if (sel == 5) run({CLS_BRANCH, 11'($random(seed))});
			else if (sel == 7) run(($random(seed) & 1) ? {3'h2, 11'($random(seed))} :
				{CLS_FILE, 3'h6 | 3'($random(seed) & 1), 8'($random(seed))});
			else run({CLS_FILE, (sel == 6) ? SUB_NOP : 3'(sel + 1), 1'($random(seed)),
				7'(m_fa)});
		end
		$display("test random mix done");
		// Write one clears the sticky illegal bit; a pending skip survives
		wrk(REG_STATUS, 32'h0000_0008);
		m_ill = 0;
		m_zero = 0;
		rd(REG_STATUS, rv, rs);
		chk(rv, m_skip * 4);
		$display("test sticky clear done");
		close_out();
	end

endmodule : ccd_core_tb_top
